// ==== hw/sat_timer.sv ====
`timescale 1ns/1ps
// How it works
// R1: unsplit, 16-bit count; on wrap from ffff reload and set high flag.
// R2: with timer interrupt enabled, every 16-bit overflow requests an interrupt.
// R3: unsplit, low-byte wrap also interrupts when low-byte enable and irq enable set.
// R4: split mode runs two 8-bit reload counters, each from its own reload byte.
// R5: in split mode run control gates only the high byte; low always counts.
// R6: byte select 1 uses system clock, else sys/12 or external/8 per alt select.
// R7: external clock divided by eight is synchronised before advancing counters.
// R8: high flag on high byte wrap; low flag on low byte wrap in both modes.
// R9: split with irq enabled: high wrap interrupts; low wrap too if enabled.
// R10: overflow flags are only ever cleared by software writing zero.
// R11: capture enabled: lfo falling edge copies count into reloads, and interrupts.
// R12: split select 0 gives 16-bit mode, 1 gives dual 8-bit mode.
// R13: run control 0 stops, 1 counts; in split mode high byte only.
// R14: unused control bit reads zero and ignores writes.
// R15: alt select picks sys/12 (0) or external/8 (1), shared by both bytes.
// R16: count_low reads low half in 16-bit mode, low counter in split mode.
// R17: unsplit, low-byte clock select clocks whole timer; high select ignored.
// R18: high-byte clock select affects only the high counter in split mode.
// R19: each enabled counter steps by one per tick; counter writes act at once.
module sat_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // clock select bits from the shared clock_select_register
  input  wire logic       low_byte_clock_select,
  input  wire logic       high_byte_clock_select,
  // global interrupt enable bit for this timer
  input  wire logic       timer_irq_enable,
  // asynchronous oscillator inputs
  input  wire logic       ext_osc,
  input  wire logic       lfo_out,
  // interrupt request, level
  output logic            irq
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rl_lo_reg, rl_lo_next;
  logic [7:0] rl_hi_reg, rl_hi_next;
  logic [7:0] cnt_lo_reg, cnt_lo_next;
  logic [7:0] cnt_hi_reg, cnt_hi_next;
  logic [3:0] div12_reg, div12_next;
  logic [2:0] lfo_sync_reg, lfo_sync_next;
  logic       cap_irq_reg, cap_irq_next;
  logic       ext_tick, sys12_tick, alt_tick;
  logic       lo_tick, hi_tick, lo_wrap, hi_wrap, lfo_fall;
  logic       split, run;
  logic       wr_ctrl, wr_rl_lo, wr_rl_hi, wr_cnt_lo, wr_cnt_hi;

  // R7
  sat_ext_tick #(
    .DIV (sat_pkg::EXT_DIV)
  ) u_ext_tick (
    .clk     (clk),
    .rst     (rst),
    .ext_osc (ext_osc),
    .tick    (ext_tick)
  );

  function automatic logic clk_pick(input logic sel, input logic sys12, input logic alt);
    // R6
    clk_pick = sel ? 1'b1 : alt;
  endfunction

  function automatic logic byte_wraps(input logic [7:0] v);
    byte_wraps = (v == sat_pkg::BYTE_ALL_ONES);
  endfunction

  assign split      = ctrl_reg[sat_pkg::BIT_SPLIT]; // R12
  assign run        = ctrl_reg[sat_pkg::BIT_RUN];
  assign sys12_tick = (div12_reg == 4'(sat_pkg::SYS_DIV - 1));
  assign alt_tick   = ctrl_reg[sat_pkg::BIT_ALT_CLK] ? ext_tick : sys12_tick; // R15
  // edge taken between the settled second and third stages, never from the first
  assign lfo_fall   = lfo_sync_reg[2] && !lfo_sync_reg[1];

  assign wr_ctrl   = sfr_wr && (sfr_addr == sat_pkg::ADDR_CONTROL);
  assign wr_rl_lo  = sfr_wr && (sfr_addr == sat_pkg::ADDR_RELOAD_LOW);
  assign wr_rl_hi  = sfr_wr && (sfr_addr == sat_pkg::ADDR_RELOAD_HIGH);
  assign wr_cnt_lo = sfr_wr && (sfr_addr == sat_pkg::ADDR_COUNT_LOW);
  assign wr_cnt_hi = sfr_wr && (sfr_addr == sat_pkg::ADDR_COUNT_HIGH);

  always_comb begin
    // R17 R18
    lo_tick = 1'b0;
    hi_tick = 1'b0;
    if (split) begin
      lo_tick = clk_pick(low_byte_clock_select, sys12_tick, alt_tick); // R5
      hi_tick = run && clk_pick(high_byte_clock_select, sys12_tick, alt_tick); // R13
    end else begin
      lo_tick = run && clk_pick(low_byte_clock_select, sys12_tick, alt_tick); // R13
      hi_tick = lo_tick && byte_wraps(cnt_lo_reg);
    end
    lo_wrap = lo_tick && byte_wraps(cnt_lo_reg);
    hi_wrap = hi_tick && byte_wraps(cnt_hi_reg);
  end

  // counters and prescaler
  // prescaler free-runs: the first sys/12 step after start comes 1 to 12 clocks later
  always_comb begin
    div12_next    = sys12_tick ? 4'h0 : div12_reg + 4'h1;
    lfo_sync_next = {lfo_sync_reg[1:0], lfo_out};
    cnt_lo_next   = cnt_lo_reg;
    cnt_hi_next   = cnt_hi_reg;
    if (split) begin
      // R4
      if (lo_tick) cnt_lo_next = lo_wrap ? rl_lo_reg : cnt_lo_reg + 8'h01; // R19
      if (hi_tick) cnt_hi_next = hi_wrap ? rl_hi_reg : cnt_hi_reg + 8'h01; // R19
    end else if (lo_tick) begin
      // R1
      if (hi_wrap) begin
        cnt_lo_next = rl_lo_reg;
        cnt_hi_next = rl_hi_reg;
      end else begin
        cnt_lo_next = cnt_lo_reg + 8'h01;
        if (lo_wrap) cnt_hi_next = cnt_hi_reg + 8'h01;
      end
    end
    // software writes take priority over counting in the same cycle
    if (wr_cnt_lo) cnt_lo_next = sfr_wdata; // R19
    if (wr_cnt_hi) cnt_hi_next = sfr_wdata; // R19
  end

  // control, reloads and capture
  always_comb begin
    ctrl_next    = ctrl_reg;
    rl_lo_next   = rl_lo_reg;
    rl_hi_next   = rl_hi_reg;
    cap_irq_next = cap_irq_reg;
    if (wr_ctrl) begin
      // R14
      ctrl_next = sfr_wdata & sat_pkg::CONTROL_WMASK;
      cap_irq_next = 1'b0;
    end
    // flag set wins over a clearing write in the same cycle
    if (hi_wrap) ctrl_next[sat_pkg::BIT_HIGH_OVF] = 1'b1; // R8 R10
    if (lo_wrap) ctrl_next[sat_pkg::BIT_LOW_OVF]  = 1'b1; // R8 R10
    if (wr_rl_lo) rl_lo_next = sfr_wdata;
    if (wr_rl_hi) rl_hi_next = sfr_wdata;
    if (ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && lfo_fall) begin
      // R11
      rl_lo_next   = cnt_lo_reg;
      rl_hi_next   = cnt_hi_reg;
      cap_irq_next = 1'b1;
    end
    if (!ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && !(ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && lfo_fall))
      cap_irq_next = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= sat_pkg::CONTROL_RESET;
      rl_lo_reg    <= sat_pkg::RELOAD_RESET;
      rl_hi_reg    <= sat_pkg::RELOAD_RESET;
      cnt_lo_reg   <= sat_pkg::COUNT_RESET;
      cnt_hi_reg   <= sat_pkg::COUNT_RESET;
      div12_reg    <= 4'h0;
      lfo_sync_reg <= 3'h0;
      cap_irq_reg  <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      rl_lo_reg    <= rl_lo_next;
      rl_hi_reg    <= rl_hi_next;
      cnt_lo_reg   <= cnt_lo_next;
      cnt_hi_reg   <= cnt_hi_next;
      div12_reg    <= div12_next;
      lfo_sync_reg <= lfo_sync_next;
      cap_irq_reg  <= cap_irq_next;
    end
  end

  // R2 R3 R9 R11
  assign irq = timer_irq_enable &&
               (ctrl_reg[sat_pkg::BIT_HIGH_OVF] ||
                (ctrl_reg[sat_pkg::BIT_LOW_IRQ_EN] && ctrl_reg[sat_pkg::BIT_LOW_OVF]) ||
                cap_irq_reg);

  always_comb begin
    // R16 R14
    unique case (sfr_addr)
      sat_pkg::ADDR_CONTROL:     sfr_rdata = ctrl_reg;
      sat_pkg::ADDR_RELOAD_LOW:  sfr_rdata = rl_lo_reg;
      sat_pkg::ADDR_RELOAD_HIGH: sfr_rdata = rl_hi_reg;
      sat_pkg::ADDR_COUNT_LOW:   sfr_rdata = cnt_lo_reg;
      sat_pkg::ADDR_COUNT_HIGH:  sfr_rdata = cnt_hi_reg;
      default:                   sfr_rdata = 8'h00;
    endcase
  end

  // checks: counting and clock selection
  a_wrap_reload: assert property (@(posedge clk) disable iff (rst) // R1
    (!split && hi_wrap && !wr_cnt_lo && !wr_cnt_hi) |=>
      (cnt_lo_reg == $past(rl_lo_reg) && cnt_hi_reg == $past(rl_hi_reg)))
    else $error("16-bit wrap did not reload");
  a_unsplit_carry: assert property (@(posedge clk) disable iff (rst) // R1
    (!split && lo_wrap && !hi_wrap && !wr_cnt_hi) |=>
      cnt_hi_reg == $past(cnt_hi_reg) + 8'h01)
    else $error("carry into high byte lost");
  a_split_lo_reload: assert property (@(posedge clk) disable iff (rst) // R4
    (split && lo_wrap && !wr_cnt_lo) |=> cnt_lo_reg == $past(rl_lo_reg))
    else $error("split low byte did not reload");
  a_split_hi_reload: assert property (@(posedge clk) disable iff (rst) // R4
    (split && hi_wrap && !wr_cnt_hi) |=> cnt_hi_reg == $past(rl_hi_reg))
    else $error("split high byte did not reload");
  a_split_low_runs: assert property (@(posedge clk) disable iff (rst) // R5
    (split && !run && low_byte_clock_select && !wr_cnt_lo && !wr_ctrl && !lo_wrap)
      |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("split low byte did not count");
  a_stopped_hold: assert property (@(posedge clk) disable iff (rst) // R13
    (!run && !wr_cnt_hi && !wr_ctrl) |=> cnt_hi_reg == $past(cnt_hi_reg))
    else $error("high byte moved while stopped");
  a_unsplit_stop: assert property (@(posedge clk) disable iff (rst) // R13
    (!split && !run && !wr_cnt_lo) |=> $stable(cnt_lo_reg))
    else $error("low byte moved while stopped");
  a_unsplit_low_sel: assert property (@(posedge clk) disable iff (rst) // R17
    (!split && run && low_byte_clock_select && !wr_cnt_lo && !hi_wrap)
      |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("whole timer not on low select clock");
  a_high_ignored: assert property (@(posedge clk) disable iff (rst) // R17
    (!split && !lo_wrap && !wr_cnt_hi) |=> $stable(cnt_hi_reg))
    else $error("high byte stepped without low wrap");
  a_split_high_sel: assert property (@(posedge clk) disable iff (rst) // R18
    (split && run && high_byte_clock_select && !wr_cnt_hi && !hi_wrap)
      |=> cnt_hi_reg == $past(cnt_hi_reg) + 8'h01)
    else $error("split high byte not on its own clock");
  a_sys12_hold: assert property (@(posedge clk) disable iff (rst) // R6
    (!split && !low_byte_clock_select && !ctrl_reg[sat_pkg::BIT_ALT_CLK] && !sys12_tick
      && !wr_cnt_lo) |=> $stable(cnt_lo_reg))
    else $error("low byte stepped between prescaler ticks");
  a_ext_hold: assert property (@(posedge clk) disable iff (rst) // R15
    (!split && !low_byte_clock_select && ctrl_reg[sat_pkg::BIT_ALT_CLK] && !ext_tick
      && !wr_cnt_lo) |=> $stable(cnt_lo_reg))
    else $error("low byte stepped without external tick");
  a_split_alt_shared: assert property (@(posedge clk) disable iff (rst) // R15
    (split && !high_byte_clock_select && ctrl_reg[sat_pkg::BIT_ALT_CLK] && !ext_tick
      && !wr_cnt_hi) |=> $stable(cnt_hi_reg))
    else $error("split high byte stepped without external tick");
  a_div12_period: assert property (@(posedge clk) disable iff (rst) // R6
    sys12_tick |=> !sys12_tick [*8] ##1 !sys12_tick [*3] ##1 sys12_tick)
    else $error("prescaler period wrong");
  a_ext_pulse: assert property (@(posedge clk) disable iff (rst) // R7
    ext_tick |=> !ext_tick) else $error("external tick longer than one cycle");
  a_write_lo: assert property (@(posedge clk) disable iff (rst) // R19
    wr_cnt_lo |=> cnt_lo_reg == $past(sfr_wdata))
    else $error("count_low write lost");
  a_write_hi: assert property (@(posedge clk) disable iff (rst) // R19
    wr_cnt_hi |=> cnt_hi_reg == $past(sfr_wdata))
    else $error("count_high write lost");

  // checks: flags and interrupts
  a_high_flag_set: assert property (@(posedge clk) disable iff (rst) // R8
    hi_wrap |=> ctrl_reg[sat_pkg::BIT_HIGH_OVF]) else $error("high flag not set");
  a_low_flag_set: assert property (@(posedge clk) disable iff (rst) // R8
    lo_wrap |=> ctrl_reg[sat_pkg::BIT_LOW_OVF]) else $error("low flag not set");
  a_flag_no_hw_clear: assert property (@(posedge clk) disable iff (rst) // R10
    ($fell(ctrl_reg[sat_pkg::BIT_HIGH_OVF]) || $fell(ctrl_reg[sat_pkg::BIT_LOW_OVF]))
      |-> $past(wr_ctrl)) else $error("flag cleared without write");
  a_high_flag_hold: assert property (@(posedge clk) disable iff (rst) // R10
    (ctrl_reg[sat_pkg::BIT_HIGH_OVF] && !wr_ctrl) |=> ctrl_reg[sat_pkg::BIT_HIGH_OVF])
    else $error("high flag dropped");
  a_low_flag_hold: assert property (@(posedge clk) disable iff (rst) // R10
    (ctrl_reg[sat_pkg::BIT_LOW_OVF] && !wr_ctrl) |=> ctrl_reg[sat_pkg::BIT_LOW_OVF])
    else $error("low flag dropped");
  a_high_irq: assert property (@(posedge clk) disable iff (rst) // R2
    (timer_irq_enable && ctrl_reg[sat_pkg::BIT_HIGH_OVF]) |-> irq)
    else $error("missing overflow interrupt");
  a_irq_gated: assert property (@(posedge clk) disable iff (rst) // R2
    !timer_irq_enable |-> !irq) else $error("interrupt while disabled");
  a_low_irq_unsplit: assert property (@(posedge clk) disable iff (rst) // R3
    (!split && lo_wrap && ctrl_reg[sat_pkg::BIT_LOW_IRQ_EN] && !wr_ctrl)
      |=> (irq || !timer_irq_enable))
    else $error("missing low byte interrupt");
  a_split_hi_irq: assert property (@(posedge clk) disable iff (rst) // R9
    (split && hi_wrap) |=> (irq || !timer_irq_enable))
    else $error("missing split high interrupt");
  a_split_lo_irq: assert property (@(posedge clk) disable iff (rst) // R9
    (split && lo_wrap && ctrl_reg[sat_pkg::BIT_LOW_IRQ_EN] && !wr_ctrl)
      |=> (irq || !timer_irq_enable))
    else $error("missing split low interrupt");
  a_capture_copy: assert property (@(posedge clk) disable iff (rst) // R11
    (ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && lfo_fall)
      |=> rl_hi_reg == $past(cnt_hi_reg) && rl_lo_reg == $past(cnt_lo_reg))
    else $error("capture did not copy count");
  a_capture_irq: assert property (@(posedge clk) disable iff (rst) // R11
    (ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && lfo_fall) |=> (irq || !timer_irq_enable))
    else $error("missing capture interrupt");
  a_cap_irq_clear: assert property (@(posedge clk) disable iff (rst) // R11
    !ctrl_reg[sat_pkg::BIT_CAPTURE_EN] |=> !cap_irq_reg)
    else $error("capture interrupt outlived its enable");

  // checks: register port
  a_unused_zero: assert property (@(posedge clk) disable iff (rst) // R14
    !ctrl_reg[sat_pkg::BIT_UNUSED]) else $error("unused bit set");
  a_rd_unused: assert property (@(posedge clk) disable iff (rst) // R14
    (sfr_addr == sat_pkg::ADDR_CONTROL) |-> !sfr_rdata[sat_pkg::BIT_UNUSED])
    else $error("unused bit read as one");

  // main scenarios
  c_wrap16: cover property (@(posedge clk) disable iff (rst) !split && hi_wrap);
  c_split_wraps: cover property (@(posedge clk) disable iff (rst) split && lo_wrap && !run);
  c_capture: cover property (@(posedge clk) disable iff (rst)
    ctrl_reg[sat_pkg::BIT_CAPTURE_EN] && lfo_fall);
  c_ext_clock: cover property (@(posedge clk) disable iff (rst)
    ctrl_reg[sat_pkg::BIT_ALT_CLK] && ext_tick && lo_tick);
  c_low_irq: cover property (@(posedge clk) disable iff (rst)
    !split && lo_wrap && ctrl_reg[sat_pkg::BIT_LOW_IRQ_EN]);
endmodule

// ==== hw/sat_pkg.sv ====
package sat_pkg;
  // special-function register addresses
  localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;

  // timer_control field positions
  localparam int BIT_HIGH_OVF   = 7;
  localparam int BIT_LOW_OVF    = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_UNUSED     = 1;
  localparam int BIT_ALT_CLK    = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  // writable bits of timer_control: all but the unused one
  localparam logic [7:0] CONTROL_WMASK = 8'hfd;

  // prescaler ratios
  localparam int SYS_DIV  = 12;
  localparam int EXT_DIV  = 8;
endpackage

// ==== hw/sat_ext_tick.sv ====
`timescale 1ns/1ps
// synchronises the external oscillator and yields one pulse per eight of its rising edges
module sat_ext_tick #(
  parameter int DIV = sat_pkg::EXT_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // external oscillator, asynchronous
  input  wire logic ext_osc,
  // one-cycle tick on clk
  output logic      tick
);
  initial begin
    if (DIV < 2 || DIV > 256) $error("DIV out of range");
  end

  logic [2:0] sync_reg, sync_next;
  logic [7:0] cnt_reg, cnt_next;
  logic       tick_next;

  always_comb begin
    sync_next = {sync_reg[1:0], ext_osc};
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    // sync_reg[0] only feeds sync_reg[1]; edge found on the settled stages
    if (sync_reg[1] && !sync_reg[2]) begin
      if (cnt_reg == 8'(DIV - 1)) begin
        cnt_next  = 8'h00;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= 3'h0;
      cnt_reg  <= 8'h00;
      tick     <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      cnt_reg  <= cnt_next;
      tick     <= tick_next;
    end
  end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       lo_sel = 1'b0;
  logic       hi_sel = 1'b0;
  logic       irq_en = 1'b0;
  logic       ext_osc = 1'b0;
  logic       lfo_out = 1'b1;
  logic       irq;
  logic [7:0] d;
  logic [7:0] e;
  int         fails = 0;
  int         cmp_count = 0;
  // rows: address, data written, value read back
  logic [7:0] rows [6][3] = '{'{8'hca, 8'h5a, 8'h5a}, '{8'hcb, 8'ha5, 8'ha5},
    '{8'hcc, 8'h3c, 8'h3c}, '{8'hcd, 8'hc3, 8'hc3}, '{8'hc8, 8'h7a, 8'h78},
    '{8'hc8, 8'h02, 8'h00}};
  sat_timer DUT (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .low_byte_clock_select(lo_sel),
    .high_byte_clock_select(hi_sel), .timer_irq_enable(irq_en), .ext_osc(ext_osc),
    .lfo_out(lfo_out), .irq(irq));
  always #5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    #1 v = sfr_rdata;
  endtask
  // bounded wait for masked register value
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    int i;
    sfr_addr = a;
    for (i = 0; i < 600; i++) begin
      @(posedge clk);
      #2;
      if ((sfr_rdata & m) === v) break;
    end
    if (i == 600) fails++;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    cyc(4);
    rst = 1'b0;
    rd(8'hc8, d); `CHK(d, 8'h00)
    rd(8'hca, d); `CHK(d, 8'h00)
    rd(8'hcc, d); `CHK(d, 8'h00)
    rd(8'h55, d); `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    for (int r = 0; r < 6; r++) begin
      wr(rows[r][0], rows[r][1]);
      rd(rows[r][0], d); `CHK(d, rows[r][2])
    end
    // 16-bit wrap at system clock, whole timer from low select
    lo_sel = 1'b1;
    irq_en = 1'b1;
    wr(8'hcb, 8'h12); wr(8'hca, 8'h34); wr(8'hcc, 8'hfe); wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    poll(8'hc8, 8'h80, 8'h80);
    wr(8'hc8, 8'h80);
    rd(8'hcd, d); `CHK(d, 8'h12)
    rd(8'hcc, d); `CHK(d >= 8'h34 && d <= 8'h3a, 1'b1)
    `CHK(irq, 1'b1)
    irq_en = 1'b0;
    cyc(20);
    rd(8'hcc, e); `CHK(e, d)
    rd(8'hc8, d); `CHK(d, 8'h80)
    `CHK(irq, 1'b0)
    wr(8'hc8, 8'h00);
    rd(8'hc8, d); `CHK(d, 8'h00)
    // split: low counts with run off, high holds
    wr(8'hca, 8'hf0); wr(8'hcc, 8'hfe); wr(8'hcd, 8'h77);
    irq_en = 1'b1;
    wr(8'hc8, 8'h08);
    poll(8'hc8, 8'h40, 8'h40);
    rd(8'hcc, d); `CHK(d >= 8'hf0, 1'b1)
    rd(8'hcd, d); `CHK(d, 8'h77)
    `CHK(irq, 1'b0)
    wr(8'hc8, 8'h68);
    `CHK(irq, 1'b1)
    // high byte runs in split mode from its own select
    hi_sel = 1'b1;
    wr(8'hcb, 8'h11); wr(8'hcd, 8'hfd); wr(8'hc8, 8'h0c);
    poll(8'hc8, 8'h80, 8'h80);
    rd(8'hcd, d); `CHK(d >= 8'h11 && d < 8'h20, 1'b1)
    `CHK(irq, 1'b1)
    // unsplit sys/12 with high select set (ignored)
    lo_sel = 1'b0;
    wr(8'hc8, 8'h00); wr(8'hcc, 8'h00); wr(8'hcd, 8'h00); wr(8'hc8, 8'h04);
    cyc(120);
    rd(8'hcc, d); `CHK(d >= 8'h09 && d <= 8'h0b, 1'b1)
    rd(8'hcd, d); `CHK(d, 8'h00)
    // external clock divided by eight, eighty slow rising edges
    wr(8'hc8, 8'h00); wr(8'hcc, 8'h00); wr(8'hc8, 8'h05);
    repeat (80) begin
      #20 ext_osc = 1'b1;
      #20 ext_osc = 1'b0;
    end
    cyc(10);
    rd(8'hcc, d); `CHK(d, 8'h0a)
    // capture on low-frequency falling edge
    wr(8'hc8, 8'h00); wr(8'hca, 8'h00); wr(8'hcb, 8'h00);
    wr(8'hcc, 8'h34); wr(8'hcd, 8'h12); wr(8'hc8, 8'h10);
    lfo_out = 1'b0;
    cyc(8);
    rd(8'hca, d); `CHK(d, 8'h34)
    rd(8'hcb, d); `CHK(d, 8'h12)
    `CHK(irq, 1'b1)
    wr(8'hc8, 8'h00);
    `CHK(irq, 1'b0)
    // unsplit low byte wrap interrupts through the low enable alone
    lo_sel = 1'b1;
    wr(8'hcc, 8'hfe); wr(8'hcd, 8'h00); wr(8'hc8, 8'h24);
    poll(8'hc8, 8'h40, 8'h40);
    `CHK(irq, 1'b1)
    rd(8'hc8, d); `CHK(d[7], 1'b0)
    wr(8'hc8, 8'h00);
    // reset in mid-run returns every register to zero
    wr(8'hca, 8'h5a); wr(8'hc8, 8'h34);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(8'hc8, d); `CHK(d, 8'h00)
    rd(8'hca, d); `CHK(d, 8'h00)
    rd(8'hcc, d); `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    final_report();
  end
endmodule
